// ===== sas_adc_sequencer.sv
`timescale 1ns/1ns
`include "sas_cfg.svh"

module sas_adc_sequencer
#(
   parameter int unsigned ADDR_W        = 18,
   parameter int unsigned SAMPLE_CYCLES = `SAS_SAMPLE_CYCLES,
   parameter int unsigned STEP_CYCLES   = `SAS_STEP_CYCLES
)
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              comp_in,
   input  wire logic              rc_tick,
   input  wire logic              special_mode,
   output sas_pkg::sas_afe_t      afe,
   output logic                   converter_power_on,
   output logic                   converter_clock_source
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic sas_hit(input logic [ADDR_W-1:0] a,
                                    input logic [15:0]       idx);
      sas_hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction : sas_hit

   // group mode takes the upper select bits and the sequence position
   function automatic logic [3:0] sas_chan(input sas_pkg::sas_ctl_t c,
                                           input logic [1:0]       pos);
      if (c.multi_channel_select)
         sas_chan = {c.channel_select_bits[3:2], pos};
      else
         sas_chan = c.channel_select_bits;
   endfunction : sas_chan

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   sas_pkg::sas_ctl_t   ctl_q;
   sas_pkg::sas_opt_t   opt_q;
   sas_pkg::sas_state_t st_q;
   logic [7:0]          res_q [`SAS_SEQ_LEN];
   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;
   logic                wr_acc;
   logic                rd_cap;
   logic                wr_ctl;
   logic                wr_opt;
   logic                is_res;
   logic [15:0]         res_off;
   logic [31:0]         rd_val;

   assign wr_acc  = psel && penable && pwrite && pready_q;
   assign rd_cap  = psel && !penable && !pwrite;
   assign wr_ctl  = wr_acc && sas_hit(paddr, `SAS_IDX_CTL);
   assign wr_opt  = wr_acc && sas_hit(paddr, `SAS_IDX_OPT);
   assign res_off = 16'(paddr[ADDR_W-1:2]) - `SAS_IDX_RES1;
   assign is_res  = paddr[1:0] == 2'b00
                    && res_off < 16'(`SAS_SEQ_LEN)
                    && paddr[ADDR_W-1:2] >= (ADDR_W-2)'(`SAS_IDX_RES1);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (sas_hit(paddr, `SAS_IDX_CTL))
         rd_val = {24'h00_0000, ctl_q};
      else if (sas_hit(paddr, `SAS_IDX_OPT))
         rd_val = {24'h00_0000, opt_q};
      else if (is_res)
         rd_val = {24'h00_0000, res_q[res_off[1:0]]};
   end

   // zero wait states: answer is ready in the first access cycle
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         pready_q  <= psel && !penable;
         pslverr_q <= psel && !penable
                      && !(sas_hit(paddr, `SAS_IDX_CTL)
                           || sas_hit(paddr, `SAS_IDX_OPT) || is_res);
         if (rd_cap)
            prdata_q <= rd_val;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // option register with write-once bits
   // ----------------------------------------------------------------
   logic [6:0] win_q;
   logic       once_q;
   logic       prot_open;
   logic [7:0] opt_new;

   assign prot_open = special_mode
                      || (!once_q && win_q < 7'(`SAS_PROT_CYCLES));
   assign opt_new   = (pwdata[7:0] & ~`SAS_OPT_PROT)
                      | ((prot_open ? pwdata[7:0] : opt_q)
                         & `SAS_OPT_PROT);

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         win_q  <= 7'h00;
         once_q <= 1'b0;
         opt_q  <= `SAS_OPT_RST;
      end
      else
      begin
         if (win_q < 7'(`SAS_PROT_CYCLES))
            win_q <= win_q + 7'h01;
         if (wr_opt)
         begin
            opt_q <= opt_new;
            if (!special_mode)
               once_q <= 1'b1;
         end
      end
   end

   assign converter_power_on     = opt_q.converter_power_on;
   assign converter_clock_source = opt_q.converter_clock_source;

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   logic       tick;
   logic [3:0] cnt_q;
   logic [1:0] conv_q;
   logic       commit;
   logic       sar_strobe;
   logic       sar_last;
   logic [7:0] trial;
   logic [3:0] chan_q;
   logic       gate_q;

   // rc pacing arrives as a synchronous tick; system clock paces always
   assign tick       = opt_q.converter_clock_source ? rc_tick : 1'b1;
   // comparator read only at the end of a settled step
   assign sar_strobe = st_q == sas_pkg::SAS_STEP && tick
                       && cnt_q == 4'(STEP_CYCLES - 1);
   // a read capture this cycle defers the store by one cycle
   assign commit     = st_q == sas_pkg::SAS_STORE && !rd_cap;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         st_q   <= sas_pkg::SAS_IDLE;
         cnt_q  <= 4'h0;
         conv_q <= 2'h0;
      end
      else if (!opt_q.converter_power_on)
         st_q <= sas_pkg::SAS_IDLE;
      else if (wr_ctl)
         st_q <= sas_pkg::SAS_START;
      else
      begin
         case (st_q)
            sas_pkg::SAS_START:
            begin
               st_q   <= sas_pkg::SAS_SAMPLE;
               cnt_q  <= 4'h0;
               conv_q <= 2'h0;
            end
            sas_pkg::SAS_SAMPLE:
               if (tick)
               begin
                  if (cnt_q == 4'(SAMPLE_CYCLES - 1))
                  begin
                     st_q  <= sas_pkg::SAS_STEP;
                     cnt_q <= 4'h0;
                  end
                  else
                     cnt_q <= cnt_q + 4'h1;
               end
            sas_pkg::SAS_STEP:
               if (tick)
               begin
                  if (cnt_q == 4'(STEP_CYCLES - 1))
                  begin
                     cnt_q <= 4'h0;
                     if (sar_last)
                        st_q <= sas_pkg::SAS_STORE;
                  end
                  else
                     cnt_q <= cnt_q + 4'h1;
               end
            sas_pkg::SAS_STORE:
               if (commit)
               begin
                  conv_q <= conv_q + 2'h1;
                  cnt_q  <= 4'h0;
                  if (conv_q == 2'(`SAS_SEQ_LEN - 1) && !ctl_q.scan)
                     st_q <= sas_pkg::SAS_IDLE;
                  else
                     st_q <= sas_pkg::SAS_SAMPLE;
               end
            default:
               st_q <= sas_pkg::SAS_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control register and completion flag
   // ----------------------------------------------------------------
   logic done_set;

   assign done_set = commit && conv_q == 2'(`SAS_SEQ_LEN - 1);

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         ctl_q <= `SAS_CTL_RST;
      else
      begin
         if (wr_ctl)
         begin
            ctl_q.scan                 <= pwdata[5];
            ctl_q.multi_channel_select <= pwdata[4];
            ctl_q.channel_select_bits  <= pwdata[3:0];
         end
         ctl_q.unused <= 1'b0;
         // completion beats a coinciding clear
         if (done_set)
            ctl_q.conversions_done_flag <= 1'b1;
         else if (wr_ctl)
            ctl_q.conversions_done_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // result registers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `SAS_SEQ_LEN; gi++)
      begin : g_res
         always_ff @(posedge clock)
         begin
            if (!rst_b)
               res_q[gi] <= 8'h00;
            else if (commit && conv_q == 2'(gi))
               res_q[gi] <= trial;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // analog front end
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         chan_q <= 4'h0;
         gate_q <= 1'b0;
      end
      else
      begin
         chan_q <= sas_chan(ctl_q, conv_q);
         gate_q <= st_q == sas_pkg::SAS_SAMPLE;
      end
   end

   sas_sar #(
      .BITS    (`SAS_SAR_BITS)
   ) u_sar (
      .clock   (clock),
      .rst_b   (rst_b),
      .load    (st_q == sas_pkg::SAS_SAMPLE),
      .strobe  (sar_strobe),
      .comp_in (comp_in),
      .trial   (trial),
      .last    (sar_last)
   );

   assign afe = {chan_q, gate_q, trial};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   logic [4:0] h_gate_q;
   always_ff @(posedge clock)
   begin
      if (!rst_b || !gate_q)
         h_gate_q <= 5'h00;
      else
         h_gate_q <= h_gate_q + 5'h01;
   end

   property p_gate_len;
      $fell(gate_q) && !$past(wr_ctl, 2) && $past(opt_q, 2) == opt_q
         && !opt_q.converter_clock_source && opt_q.converter_power_on
         |-> h_gate_q == 5'(SAMPLE_CYCLES);
   endproperty
   a_gate_len: assert property (p_gate_len)
      else $error("sample gate length wrong");

   property p_start;
      wr_ctl && opt_q.converter_power_on && !wr_opt
         |=> st_q == sas_pkg::SAS_START
         ##1 (st_q == sas_pkg::SAS_SAMPLE || !opt_q.converter_power_on
              || $past(wr_ctl));
   endproperty
   a_start: assert property (p_start)
      else $error("sequence did not start one cycle after write");

   property p_done_clr;
      wr_ctl && !done_set |=> !ctl_q.conversions_done_flag;
   endproperty
   a_done_clr: assert property (p_done_clr)
      else $error("done flag not cleared by control write");

   property p_done_set;
      done_set |=> ctl_q.conversions_done_flag
                   && res_q[`SAS_SEQ_LEN-1] == $past(trial);
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag or last result missing");

   property p_once;
      done_set && !ctl_q.scan && !wr_ctl && opt_q.converter_power_on
         |=> st_q == sas_pkg::SAS_IDLE;
   endproperty
   a_once: assert property (p_once)
      else $error("single sequence did not halt");

   property p_group;
      gate_q && ctl_q.multi_channel_select && $stable(ctl_q)
         |-> chan_q == {ctl_q.channel_select_bits[3:2], $past(conv_q)};
   endproperty
   a_group: assert property (p_group)
      else $error("group channel mismatch");

   property p_prot;
      wr_opt && !prot_open |=> (opt_q & `SAS_OPT_PROT)
                               == ($past(opt_q) & `SAS_OPT_PROT);
   endproperty
   a_prot: assert property (p_prot)
      else $error("protected option bits changed late");

   property p_no_clash;
      rd_cap && st_q == sas_pkg::SAS_STORE |=> $stable(res_q[0])
         && $stable(res_q[1]) && $stable(res_q[2]) && $stable(res_q[3]);
   endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("result updated during read");

   property p_power;
      !opt_q.converter_power_on |=> st_q == sas_pkg::SAS_IDLE ##1 !gate_q;
   endproperty
   a_power: assert property (p_power)
      else $error("converter active while powered down");

endmodule : sas_adc_sequencer

// ===== sas_afe_model.sv
`timescale 1ns/1ns

module sas_afe_model
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire sas_pkg::sas_afe_t afe,
   input  wire logic              power_on,
   input  wire logic [15:0][7:0]  in_lvl,
   output logic                   comp_in
);
   logic [7:0] pin_v;
   logic [7:0] held_q;
   logic       junk_q;

   always_comb
   begin
      case (afe.chan)
         4'hC:    pin_v = 8'hFF;
         4'hD:    pin_v = 8'h00;
         4'hE:    pin_v = 8'h80;
         default: pin_v = in_lvl[afe.chan];
      endcase
   end

   // pins reach the array only through the switch, no digital read
   // array keeps only what it saw while the input switch was closed
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         held_q <= 8'h00;
      else if (afe.sample_gate)
         held_q <= pin_v;
   end

   // unpowered comparator gives no usable answer, so it wanders
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         junk_q <= 1'b0;
      else
         junk_q <= ~junk_q;
   end

   assign comp_in = power_on ? (held_q >= afe.trial) : junk_q;
endmodule : sas_afe_model

// ===== sas_cfg.svh
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define SAS_IDX_CTL      16'h1030
`define SAS_IDX_RES1     16'h1031
`define SAS_IDX_RES4     16'h1034
`define SAS_IDX_OPT      16'h1039

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define SAS_CTL_RST      8'h80
`define SAS_OPT_RST      8'h10
`define SAS_OPT_PROT     8'h33
`define SAS_CTL_DONE     7
`define SAS_CTL_ZERO     6

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SAS_PROT_CYCLES   64
`define SAS_SAMPLE_CYCLES 12
`define SAS_STEP_CYCLES   4
`define SAS_SAR_BITS      8
`define SAS_SEQ_LEN       4

`endif

// ===== sas_pkg.sv
package sas_pkg;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SAS_IDLE   = 3'b000,
      SAS_START  = 3'b001,
      SAS_SAMPLE = 3'b010,
      SAS_STEP   = 3'b011,
      SAS_STORE  = 3'b100
   } sas_state_t;

   // ----------------------------------------------------------------
   // register layouts
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic       conversions_done_flag;
      logic       unused;
      logic       scan;
      logic       multi_channel_select;
      logic [3:0] channel_select_bits;
   } sas_ctl_t;

   typedef struct packed
   {
      logic       converter_power_on;
      logic       converter_clock_source;
      logic       edge_irq_config;
      logic       startup_delay_enable;
      logic       clock_watch_enable;
      logic       forced_clock_watch;
      logic [1:0] watchdog_rate_select;
   } sas_opt_t;

   // analog front-end drive
   typedef struct packed
   {
      logic [3:0] chan;
      logic       sample_gate;
      logic [7:0] trial;
   } sas_afe_t;

endpackage : sas_pkg

// ===== sas_sar.sv
`timescale 1ns/1ns
`include "sas_cfg.svh"

module sas_sar
#(
   parameter int unsigned BITS = `SAS_SAR_BITS
)
(
   input  wire logic            clock,
   input  wire logic            rst_b,
   input  wire logic            load,
   input  wire logic            strobe,
   input  wire logic            comp_in,
   output logic [BITS-1:0]      trial,
   output logic                 last
);

   // ----------------------------------------------------------------
   // successive approximation, msb first
   // ----------------------------------------------------------------
   logic [BITS-1:0] code_q;
   logic [BITS-1:0] bit_q;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         code_q <= '0;
         bit_q  <= '0;
      end
      else if (load)
      begin
         code_q <= {1'b1, {(BITS-1){1'b0}}};
         bit_q  <= {1'b1, {(BITS-1){1'b0}}};
      end
      else if (strobe && bit_q != '0)
      begin
         // comparator low drops the trial bit; full scale saturates
         code_q <= (comp_in ? code_q : (code_q & ~bit_q))
                   | (bit_q >> 1);
         bit_q  <= bit_q >> 1;
      end
   end

   assign trial = code_q;
   assign last  = bit_q[0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_sar_drop;
      @(posedge clock) disable iff (!rst_b)
      strobe && !load && !comp_in && bit_q != '0
         |=> (code_q & $past(bit_q)) == '0;
   endproperty
   a_sar_drop: assert property (p_sar_drop)
      else $error("rejected trial bit kept");

   property p_sar_msb;
      @(posedge clock) disable iff (!rst_b)
      load ##1 !load |-> bit_q == {1'b1, {(BITS-1){1'b0}}};
   endproperty
   a_sar_msb: assert property (p_sar_msb)
      else $error("conversion not starting at msb");

endmodule : sas_sar

// ===== tb_top.sv
`timescale 1ns/1ns
`include "sas_cfg.svh"

module tb_top;
   localparam logic [17:0] A_CTL  = {`SAS_IDX_CTL, 2'b00};
   localparam logic [17:0] A_RES1 = {`SAS_IDX_RES1, 2'b00};
   localparam logic [17:0] A_OPT  = {`SAS_IDX_OPT, 2'b00};

   logic              clock = 1'b0;
   logic              rst_b = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [17:0]       paddr = 18'h00000;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              comp_in;
   logic              rc_tick = 1'b0;
   logic              special_mode = 1'b0;
   sas_pkg::sas_afe_t afe;
   logic              pwr_on;
   logic              clk_src;
   logic [15:0][7:0]  lvl;
   logic [31:0]       q;
   logic              e;
   logic [7:0]        tr;
   logic [3:0][7:0]   ex;
   int                n_errors = 0;
   int                samples_checked = 0;
   int                cyc = 0;
   int                r;
   int                w;

   always #20 clock = ~clock;

   sas_adc_sequencer u_sas_adc_sequencer
   (
      .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
      .rc_tick(rc_tick), .special_mode(special_mode), .afe(afe),
      .converter_power_on(pwr_on), .converter_clock_source(clk_src)
   );

   sas_afe_model u_sas_afe_model
   (
      .clock(clock), .rst_b(rst_b), .afe(afe), .power_on(pwr_on),
      .in_lvl(lvl), .comp_in(comp_in)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task wrap_up;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      rc_tick <= (cyc % 3 == 2);
      if (cyc == 20000)
      begin
         n_errors++;
         wrap_up();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // request held until pready is seen at a rising edge
   task apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // no own limit: only the cycle ceiling ends a hung access
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_done(input int lim);
      int k;
      k = 0;
      do
      begin
         apb(1'b0, A_CTL, 32'h0);
         k++;
      end
      while (q[7] !== 1'b1 && k < lim);
   endtask : wait_done

   task chk_res(input logic [3:0][7:0] exp);
      for (int j = 0; j < 4; j++)
      begin
         apb(1'b0, A_RES1 + 18'(4 * j), 32'h0);
         chk(q, {24'h0, exp[j]});
      end
   endtask : chk_res

   task gate_time(output int rise, output int wid);
      rise = 0;
      wid = 0;
      do
      begin
         @(posedge clock);
         #1;
         rise++;
      end
      while (afe.sample_gate !== 1'b1 && rise < 200);
      tr = afe.trial;
      while (afe.sample_gate === 1'b1 && wid < 200)
      begin
         @(posedge clock);
         #1;
         wid++;
      end
   endtask : gate_time

   function automatic logic [7:0] lvl_of(input int ch);
      case (ch)
         12:      return 8'hFF;
         13:      return 8'h00;
         14:      return 8'h80;
         default: return lvl[ch];
      endcase
   endfunction : lvl_of

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial
   begin
      for (int i = 0; i < 16; i++)
         lvl[i] = {i[3:0], ~i[3:0]};
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      apb(1'b1, A_OPT, 32'h81);
      apb(1'b0, A_OPT, 32'h0);
      chk(q, 32'h81);
      chk({31'h0, pwr_on}, 32'h1);
      apb(1'b1, A_OPT, 32'hB2);
      apb(1'b0, A_OPT, 32'h0);
      chk(q, 32'h81);
      special_mode <= 1'b1;
      apb(1'b1, A_OPT, 32'hB2);
      apb(1'b0, A_OPT, 32'h0);
      chk(q, 32'hB2);
      special_mode <= 1'b0;
      apb(1'b0, A_CTL, 32'h0);
      chk(q, 32'h80);
      apb(1'b0, 18'h3FFFC, 32'h0);
      chk({q[30:0], e}, 32'h1);
      apb(1'b1, A_RES1, 32'hAA);
      apb(1'b0, A_RES1, 32'h0);
      chk(q, 32'h0);
      // settling time after power-up, 100 us at 25 MHz
      repeat (2500) @(posedge clock);
      // 25 MHz is far above 750 kHz, so the system clock is used
      apb(1'b1, A_CTL, 32'h05);
      gate_time(r, w);
      chk(32'(r), 32'd2);
      chk(32'(w), 32'd12);
      chk({24'h0, tr}, 32'h80);
      chk({28'h0, afe.chan}, 32'h5);
      apb(1'b0, A_CTL, 32'h0);
      chk(q, 32'h05);
      wait_done(300);
      chk(q, 32'h85);
      chk_res({4{lvl[5]}});
      for (int g = 0; g < 4; g++)
      begin
         apb(1'b1, A_CTL, 32'(16 + 4 * g));
         wait_done(300);
         chk(q, 32'(144 + 4 * g));
         for (int k = 0; k < 4; k++)
            ex[k] = lvl_of(4 * g + k);
         chk_res(ex);
      end
      apb(1'b1, A_CTL, 32'h02);
      repeat (30) @(posedge clock);
      apb(1'b1, A_CTL, 32'h07);
      wait_done(300);
      chk(q, 32'h87);
      chk_res({4{lvl[7]}});
      apb(1'b1, A_CTL, 32'h25);
      wait_done(300);
      chk(q, 32'hA5);
      lvl[5] <= 8'hC3;
      repeat (400) @(posedge clock);
      apb(1'b0, A_CTL, 32'h0);
      chk(q, 32'hA5);
      chk_res({4{8'hC3}});
      apb(1'b1, A_OPT, 32'hC0);
      apb(1'b1, A_CTL, 32'h03);
      chk({31'h0, clk_src}, 32'h1);
      gate_time(r, w);
      chk({31'h0, (w >= 33 && w <= 37)}, 32'h1);
      wait_done(2000);
      chk(q, 32'h83);
      chk_res({4{lvl[3]}});
      apb(1'b1, A_OPT, 32'h00);
      apb(1'b1, A_CTL, 32'h01);
      chk({31'h0, pwr_on}, 32'h0);
      repeat (300) @(posedge clock);
      apb(1'b0, A_CTL, 32'h0);
      chk(q, 32'h01);
      wrap_up();
   end
endmodule : tb_top
